// [ldc_host_model.sv]
`timescale 1ns/1ps

// ****************************************
// Host side of the register port
// ****************************************
module ldc_host_model (
    input wire logic clk_sys_i,
    input wire logic [7:0] reg_rdata_i,
    output logic en_pin_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o
);
    initial begin
        en_pin_o = 1'b1;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end

    task automatic set_pin(input logic v);
        @(posedge clk_sys_i);
        en_pin_o <= v;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_o <= 1'b0;
        reg_wdata_o <= ~d;
    endtask

    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~a;
        #1;
        d = reg_rdata_i;
    endtask
endmodule

// [ldc_led_ctrl.sv]
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps

// Operation
// - Enable pin low in enable mode disables everything and resets all registers.
// - Pin-function bit 7 of general register at 0 (default): pin is chip enable.
// - Enable pin high keeps the register port active.
// - Each LED switches on or off per its general register enable bit.
// - Register reads and writes work whether LEDs are lit or not.
// - Bit 7 at 1 turns the enable pin into a PWM dimming input.
// - In PWM mode LED current flows while pin high, gated off while low.
// - Register level sets on-current amplitude, PWM pin sets its duty.
// - Writing 0 to bit 7 restores the chip enable function.
// - Each bank has 64 exponential brightness levels chosen by register writes.
// - After reset six sinks form five banks 2,1,1,1,1; first two are group A.
// - Host may move any LED into group A, up to all six.
// - Full-scale current is a factory constant; code scales it as a percentage.
// - Stay in 1x pump until an active LED loses regulation, then 1.5x.
// - In 1.5x, return to 1x once lowest active cathode exceeds 1.8 V.
// - Code 000000 gives 0.125 percent, 111111 gives 100 percent, monotonic between.
// - Group A steps one level at a time; ramp field picks 0.1/25/50/100 ms.
module ldc_led_ctrl #(
    parameter int FULL_SCALE_UA = ldc_pkg::FULL_SCALE_UA_DEFAULT,
    parameter int STEP_CYC_0 = ldc_pkg::RAMP_STEP0_US * ldc_pkg::NS_PER_US / ldc_pkg::CLK_PERIOD_NS,
    parameter int STEP_CYC_1 = ldc_pkg::RAMP_STEP1_US * ldc_pkg::NS_PER_US / ldc_pkg::CLK_PERIOD_NS,
    parameter int STEP_CYC_2 = ldc_pkg::RAMP_STEP2_US * ldc_pkg::NS_PER_US / ldc_pkg::CLK_PERIOD_NS,
    parameter int STEP_CYC_3 = ldc_pkg::RAMP_STEP3_US * ldc_pkg::NS_PER_US / ldc_pkg::CLK_PERIOD_NS
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic en_pin_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [5:0] led_reg_loss_i,
    input wire logic [5:0] led_cath_above_1v8_i,
    output logic [5:0] led_on_o,
    output logic [5:0][15:0] led_current_ua_o,
    output logic pump_1p5x_o,
    output logic chip_enabled_o
);

    // ****************************************
    // Enable pin function and register reset
    // ****************************************
    logic pin_pwm_reg;
    logic chip_en;
    logic dis_rst;

    assign chip_en = pin_pwm_reg | en_pin_i;
    assign dis_rst = rst_i | ~chip_en;
    assign chip_enabled_o = chip_en;

    // ****************************************
    // Control registers
    // ****************************************
    logic [5:0] led_en_reg;
    logic [5:0] group_mask_reg;
    logic [1:0] ramp_reg;
    logic [ldc_pkg::BANK_COUNT-1:0][5:0] bank_code_reg;
    logic wr_ok;

    // Writes are honoured regardless of LED state while the chip is enabled
    assign wr_ok = reg_wr_i & chip_en;

    always_ff @(posedge clk_sys_i) begin
        if (dis_rst) begin
            pin_pwm_reg <= 1'b0;
            led_en_reg <= ldc_pkg::LED_EN_RESET;
        end else if (wr_ok && reg_addr_i == ldc_pkg::ADDR_GP) begin
            pin_pwm_reg <= reg_wdata_i[ldc_pkg::GP_PIN_PWM_BIT];
            led_en_reg <= reg_wdata_i[5:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (dis_rst) begin
            group_mask_reg <= ldc_pkg::GROUP_MASK_RESET;
            ramp_reg <= ldc_pkg::RAMP_RESET;
        end else if (wr_ok && reg_addr_i == ldc_pkg::ADDR_GROUP) begin
            group_mask_reg <= reg_wdata_i[5:0] | ldc_pkg::GROUP_FIXED_MASK;
            ramp_reg <= reg_wdata_i[ldc_pkg::GROUP_RAMP_LSB +: 2];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (dis_rst) begin
            for (int b = 0; b < ldc_pkg::BANK_COUNT; b++) begin
                bank_code_reg[b] <= ldc_pkg::CODE_RESET;
            end
        end else if (wr_ok && reg_addr_i >= ldc_pkg::ADDR_BANK_A && reg_addr_i <= ldc_pkg::ADDR_BANK_E) begin
            bank_code_reg[3'(reg_addr_i - ldc_pkg::ADDR_BANK_A)] <= reg_wdata_i[5:0];
        end
    end

    // ****************************************
    // Group A ramp
    // ****************************************
    logic [5:0] cur_a_reg;
    logic [23:0] ramp_timer_reg;
    logic [23:0] step_limit;
    logic ramp_busy;
    logic step_due;

    always_comb begin
        case (ramp_reg)
            2'h0: step_limit = 24'(STEP_CYC_0 - 1);
            2'h1: step_limit = 24'(STEP_CYC_1 - 1);
            2'h2: step_limit = 24'(STEP_CYC_2 - 1);
            default: step_limit = 24'(STEP_CYC_3 - 1);
        endcase
    end

    assign ramp_busy = cur_a_reg != bank_code_reg[0];
    assign step_due = ramp_busy && ramp_timer_reg >= step_limit;

    always_ff @(posedge clk_sys_i) begin
        if (dis_rst || !ramp_busy || step_due) begin
            ramp_timer_reg <= 24'h00_0000;
        end else begin
            ramp_timer_reg <= ramp_timer_reg + 24'h00_0001;
        end
    end

    // One level per step toward the target
    always_ff @(posedge clk_sys_i) begin
        if (dis_rst) begin
            cur_a_reg <= ldc_pkg::CODE_RESET;
        end else if (step_due && cur_a_reg < bank_code_reg[0]) begin
            cur_a_reg <= cur_a_reg + 6'h01;
        end else if (step_due) begin
            cur_a_reg <= cur_a_reg - 6'h01;
        end
    end

    // ****************************************
    // Bank level scan through the table
    // ****************************************
    ldc_level_if lvl_bus ();

    ldc_level_rom u_rom (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .lvl(lvl_bus.rom)
    );

    logic [2:0] scan_reg;
    logic [2:0] capture_reg;
    logic [ldc_pkg::BANK_COUNT-1:0][15:0] bank_ua_reg;
    logic [39:0] level_prod;
    logic [15:0] level_ua;

    assign lvl_bus.rd_addr = (scan_reg == 3'h0) ? cur_a_reg : bank_code_reg[scan_reg];

    // Amplitude is the table fraction of the factory full scale
    assign level_prod = 40'(lvl_bus.rd_data) * 40'(FULL_SCALE_UA);
    assign level_ua = 16'(level_prod / 40'(ldc_pkg::LEVEL_FULL));

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            scan_reg <= 3'h0;
            capture_reg <= 3'h0;
        end else begin
            capture_reg <= scan_reg;
            if (scan_reg == 3'(ldc_pkg::BANK_COUNT - 1)) begin
                scan_reg <= 3'h0;
            end else begin
                scan_reg <= scan_reg + 3'h1;
            end
        end
    end

    // Each bank is refreshed in its own slot only, others keep their value
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            bank_ua_reg <= '0;
        end else begin
            bank_ua_reg[capture_reg] <= level_ua;
        end
    end

    // ****************************************
    // LED outputs
    // ****************************************
    logic [5:0] led_on;

    // Pin high is both enable and PWM on-phase
    assign led_on = led_en_reg & {6{chip_en & en_pin_i}};

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            led_on_o <= 6'h00;
            led_current_ua_o <= '0;
        end else begin
            led_on_o <= led_on;
            led_current_ua_o[0] <= bank_ua_reg[0];
            for (int k = 1; k < ldc_pkg::LED_COUNT; k++) begin
                if (group_mask_reg[k]) begin
                    led_current_ua_o[k] <= bank_ua_reg[0];
                end else begin
                    led_current_ua_o[k] <= bank_ua_reg[k - 1];
                end
            end
        end
    end

    // ****************************************
    // Charge pump mode
    // ****************************************
    ldc_pkg::ldc_pump_e pump_reg;

    always_ff @(posedge clk_sys_i) begin
        if (dis_rst) begin
            pump_reg <= ldc_pkg::PUMP_1X;
        end else begin
            case (pump_reg)
                ldc_pkg::PUMP_1X: begin
                    if (|(led_reg_loss_i & led_on)) begin
                        pump_reg <= ldc_pkg::PUMP_1P5X;
                    end
                end
                default: begin
                    if (&(led_cath_above_1v8_i | ~led_on)) begin
                        pump_reg <= ldc_pkg::PUMP_1X;
                    end
                end
            endcase
        end
    end

    assign pump_1p5x_o = pump_reg == ldc_pkg::PUMP_1P5X;

    // ****************************************
    // Register read port
    // ****************************************
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || !chip_en || !reg_rd_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_addr_i == ldc_pkg::ADDR_GP) begin
            reg_rdata_o <= {pin_pwm_reg, 1'b0, led_en_reg};
        end else if (reg_addr_i == ldc_pkg::ADDR_GROUP) begin
            reg_rdata_o <= {ramp_reg, group_mask_reg};
        end else if (reg_addr_i >= ldc_pkg::ADDR_BANK_A && reg_addr_i <= ldc_pkg::ADDR_BANK_E) begin
            reg_rdata_o <= {2'h0, bank_code_reg[3'(reg_addr_i - ldc_pkg::ADDR_BANK_A)]};
        end else if (reg_addr_i == ldc_pkg::ADDR_STATUS) begin
            reg_rdata_o <= {cur_a_reg, ramp_busy, pump_1p5x_o};
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

endmodule

// [ldc_led_ctrl_props.sv]
`timescale 1ns/1ps

module ldc_led_ctrl_props (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic en_pin_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [5:0] led_reg_loss_i,
    input wire logic [5:0] led_on_o,
    input wire logic pump_1p5x_o,
    input wire logic chip_enabled_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    // Shadow of the pin-function bit
    logic pwm_reg;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pwm_reg <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == ldc_pkg::ADDR_GP && (pwm_reg || en_pin_i)) begin
            pwm_reg <= reg_wdata_i[ldc_pkg::GP_PIN_PWM_BIT];
        end
    end

    rdata_idle_a: assert property (
        !reg_rd_i |=> reg_rdata_o == 8'h00) else $error("read data not zero outside read slot");
    pin_function_a: assert property (
        chip_enabled_o == (pwm_reg || en_pin_i)) else $error("chip enable does not follow pin function");
    disabled_read_a: assert property (
        reg_rd_i && !chip_enabled_o |=> reg_rdata_o == 8'h00) else $error("read answered while disabled");
    pin_low_dark_a: assert property (
        !pwm_reg && !en_pin_i |=> led_on_o == 6'h00) else $error("led lit while chip disabled");
    gate_by_pin_a: assert property (
        |led_on_o |-> $past(en_pin_i)) else $error("led lit after pin low");
    gp_readback_a: assert property (
        reg_wr_i && reg_addr_i == ldc_pkg::ADDR_GP && chip_enabled_o ##1 !reg_wr_i
        ##1 reg_rd_i && reg_addr_i == ldc_pkg::ADDR_GP && chip_enabled_o
        |=> reg_rdata_o == ($past(reg_wdata_i, 3) & 8'hBF)) else $error("general register readback wrong");
    group_fixed_a: assert property (
        reg_rd_i && reg_addr_i == ldc_pkg::ADDR_GROUP && chip_enabled_o
        |=> reg_rdata_o[1:0] == 2'b11) else $error("first two leds left group A");
    status_pump_a: assert property (
        reg_rd_i && reg_addr_i == ldc_pkg::ADDR_STATUS && chip_enabled_o
        |=> reg_rdata_o[ldc_pkg::STATUS_PUMP_BIT] == $past(pump_1p5x_o)) else $error("status pump bit wrong");
    pump_rise_a: assert property (
        !pump_1p5x_o && |(led_reg_loss_i & led_on_o) ##1 $stable(led_on_o)
        |-> pump_1p5x_o) else $error("pump stayed 1x on regulation loss");
endmodule

bind ldc_led_ctrl ldc_led_ctrl_props u_props (.clk_sys_i, .rst_i, .en_pin_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .led_reg_loss_i, .led_on_o, .pump_1p5x_o, .chip_enabled_o);

// [ldc_level_if.sv]
`timescale 1ns/1ps

interface ldc_level_if;
    logic [5:0] rd_addr;
    logic [16:0] rd_data;

    modport reader (output rd_addr, input rd_data);
    modport rom (input rd_addr, output rd_data);
endinterface

// [ldc_level_rom.sv]
`timescale 1ns/1ps

// ****************************************
// Brightness code to level, thousandths of a percent
// ****************************************
module ldc_level_rom (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    ldc_level_if.rom lvl
);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            lvl.rd_data <= 17'h0_0000;
        end else begin
            case (lvl.rd_addr)
                6'h00: lvl.rd_data <= 17'h0_007D;
                6'h01: lvl.rd_data <= 17'h0_00BC;
                6'h02: lvl.rd_data <= 17'h0_00F9;
                6'h03: lvl.rd_data <= 17'h0_0138;
                6'h04: lvl.rd_data <= 17'h0_0176;
                6'h05: lvl.rd_data <= 17'h0_01B6;
                6'h06: lvl.rd_data <= 17'h0_01F3;
                6'h07: lvl.rd_data <= 17'h0_0230;
                6'h08: lvl.rd_data <= 17'h0_026E;
                6'h09: lvl.rd_data <= 17'h0_02B4;
                6'h0A: lvl.rd_data <= 17'h0_02EE;
                6'h0B: lvl.rd_data <= 17'h0_032A;
                6'h0C: lvl.rd_data <= 17'h0_036B;
                6'h0D: lvl.rd_data <= 17'h0_03AA;
                6'h0E: lvl.rd_data <= 17'h0_03EC;
                6'h0F: lvl.rd_data <= 17'h0_0464;
                6'h10: lvl.rd_data <= 17'h0_04E2;
                6'h11: lvl.rd_data <= 17'h0_055F;
                6'h12: lvl.rd_data <= 17'h0_05DB;
                6'h13: lvl.rd_data <= 17'h0_0659;
                6'h14: lvl.rd_data <= 17'h0_06D6;
                6'h15: lvl.rd_data <= 17'h0_0759;
                6'h16: lvl.rd_data <= 17'h0_080F;
                6'h17: lvl.rd_data <= 17'h0_08C9;
                6'h18: lvl.rd_data <= 17'h0_0986;
                6'h19: lvl.rd_data <= 17'h0_0A7F;
                6'h1A: lvl.rd_data <= 17'h0_0B7B;
                6'h1B: lvl.rd_data <= 17'h0_0C72;
                6'h1C: lvl.rd_data <= 17'h0_0DEA;
                6'h1D: lvl.rd_data <= 17'h0_0F60;
                6'h1E: lvl.rd_data <= 17'h0_10D6;
                6'h1F: lvl.rd_data <= 17'h0_12CD;
                6'h20: lvl.rd_data <= 17'h0_14C2;
                6'h21: lvl.rd_data <= 17'h0_1730;
                6'h22: lvl.rd_data <= 17'h0_19A5;
                6'h23: lvl.rd_data <= 17'h0_1C91;
                6'h24: lvl.rd_data <= 17'h0_1F7B;
                6'h25: lvl.rd_data <= 17'h0_22EA;
                6'h26: lvl.rd_data <= 17'h0_2694;
                6'h27: lvl.rd_data <= 17'h0_2A7A;
                6'h28: lvl.rd_data <= 17'h0_2EE5;
                6'h29: lvl.rd_data <= 17'h0_33C5;
                6'h2A: lvl.rd_data <= 17'h0_391A;
                6'h2B: lvl.rd_data <= 17'h0_3EFC;
                6'h2C: lvl.rd_data <= 17'h0_45D9;
                6'h2D: lvl.rd_data <= 17'h0_4DA3;
                6'h2E: lvl.rd_data <= 17'h0_5669;
                6'h2F: lvl.rd_data <= 17'h0_602D;
                6'h30: lvl.rd_data <= 17'h0_6AF0;
                6'h31: lvl.rd_data <= 17'h0_76A5;
                6'h32: lvl.rd_data <= 17'h0_8357;
                6'h33: lvl.rd_data <= 17'h0_9104;
                6'h34: lvl.rd_data <= 17'h0_9FA9;
                6'h35: lvl.rd_data <= 17'h0_AF4B;
                6'h36: lvl.rd_data <= 17'h0_BFE4;
                6'h37: lvl.rd_data <= 17'h0_D178;
                6'h38: lvl.rd_data <= 17'h0_E407;
                6'h39: lvl.rd_data <= 17'h0_F792;
                6'h3A: lvl.rd_data <= 17'h1_0C11;
                6'h3B: lvl.rd_data <= 17'h1_218A;
                6'h3C: lvl.rd_data <= 17'h1_3802;
                6'h3D: lvl.rd_data <= 17'h1_4F71;
                6'h3E: lvl.rd_data <= 17'h1_68D5;
                default: lvl.rd_data <= 17'h1_86A0;
            endcase
        end
    end

endmodule

// [ldc_pkg.sv]
package ldc_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int LED_COUNT = 6;
    localparam int BANK_COUNT = 5;
    localparam int CODE_W = 6;
    localparam int LEVEL_W = 17;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int UA_W = 16;
    localparam int TIMER_W = 24;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ADDR_GP = 8'h00;
    localparam logic [7:0] ADDR_GROUP = 8'h01;
    localparam logic [7:0] ADDR_BANK_A = 8'h02;
    localparam logic [7:0] ADDR_BANK_E = 8'h06;
    localparam logic [7:0] ADDR_STATUS = 8'h07;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int GP_PIN_PWM_BIT = 7;
    localparam int GROUP_RAMP_LSB = 6;
    localparam int STATUS_PUMP_BIT = 0;
    localparam int STATUS_BUSY_BIT = 1;
    localparam int STATUS_LEVEL_LSB = 2;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [5:0] LED_EN_RESET = 6'h00;
    localparam logic [5:0] GROUP_MASK_RESET = 6'h03;
    localparam logic [5:0] GROUP_FIXED_MASK = 6'h03;
    localparam logic [1:0] RAMP_RESET = 2'h0;
    localparam logic [5:0] CODE_RESET = 6'h00;

    // Table value of full scale, in thousandths of a percent
    localparam logic [16:0] LEVEL_FULL = 17'h1_86A0;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int NS_PER_US = 1000;
    localparam int RAMP_STEP0_US = 100;
    localparam int RAMP_STEP1_US = 25000;
    localparam int RAMP_STEP2_US = 50000;
    localparam int RAMP_STEP3_US = 100000;
    localparam int FULL_SCALE_UA_DEFAULT = 20000;

    typedef enum logic {
        PUMP_1X = 1'b0,
        PUMP_1P5X = 1'b1
    } ldc_pump_e;

endpackage

// [led_bank_dimming_control_test.sv]
`timescale 1ns/1ps

module led_bank_dimming_control_test;
    localparam int FS_UA = ldc_pkg::FULL_SCALE_UA_DEFAULT;
    localparam int STEP_C [4] = '{4, 6, 8, 10};
    logic clk_sys_i;
    logic rst_i;
    logic en_pin, reg_wr, reg_rd, pump, chip_en;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, r, v;
    logic [5:0] loss;
    logic [5:0] cath;
    logic [5:0] led_on;
    logic [5:0][15:0] cur_ua;
    int mismatches = 0;
    int checks = 0;
    int cyc = 0;

    ldc_host_model u_host (.clk_sys_i(clk_sys_i), .reg_rdata_i(reg_rdata), .en_pin_o(en_pin),
        .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd));
    ldc_led_ctrl #(.STEP_CYC_0(4), .STEP_CYC_1(6), .STEP_CYC_2(8), .STEP_CYC_3(10)) u_dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .en_pin_i(en_pin), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .led_reg_loss_i(loss),
        .led_cath_above_1v8_i(cath), .led_on_o(led_on), .led_current_ua_o(cur_ua), .pump_1p5x_o(pump),
        .chip_enabled_o(chip_en));

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // ****************************************
    // Checks
    // ****************************************
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t %s got %0d exp %0d", $time, what, got, exp);
        end
    endtask

    function automatic logic [15:0] ua_of(input logic [5:0] code);
        return 16'(((code == 6'h3F) ? 100000 : 125) * FS_UA / 100000);
    endfunction

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        u_host.rd(a, v);
        chk8(v, exp, what);
    endtask

    // Set bit k: led k at full code, else at lowest code
    task automatic cur_chk(input logic [5:0] full);
        for (int k = 0; k < 6; k++) begin
            chk16(cur_ua[k], full[k] ? ua_of(6'h3F) : ua_of(6'h00), "led current");
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 6000) begin
            mismatches++;
            end_sim();
        end
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        rst_i = 1'b1;
        loss = 6'h00;
        cath = 6'h00;
        void'($urandom(32'h460610ed));
        repeat (8) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd_chk(ldc_pkg::ADDR_GP, 8'h00, "gp reset");
        rd_chk(ldc_pkg::ADDR_GROUP, 8'h03, "group reset");
        for (int b = 0; b < 5; b++) begin
            rd_chk(ldc_pkg::ADDR_BANK_A + 8'(b), 8'h00, "bank reset");
        end
        rd_chk(8'h08, 8'h00, "unmapped");
        $display("test reset values done");
        for (int i = 0; i < 16; i++) begin
            r = 8'($urandom) & 8'h7F;
            u_host.wr(ldc_pkg::ADDR_GP, r);
            rd_chk(ldc_pkg::ADDR_GP, r & 8'hBF, "gp readback");
            chk8({2'b00, led_on}, {2'b00, r[5:0]}, "led gate");
            r = 8'($urandom);
            u_host.wr(ldc_pkg::ADDR_GROUP, r);
            rd_chk(ldc_pkg::ADDR_GROUP, r | 8'h03, "group readback");
            r = ldc_pkg::ADDR_BANK_A + 8'($urandom_range(4));
            u_host.wr(r, 8'(i * 4 + 3));
            rd_chk(r, 8'(i * 4 + 3), "bank readback");
        end
        $display("test register access done");
        u_host.wr(ldc_pkg::ADDR_GP, 8'h3F);
        u_host.wr(8'h03, 8'h3F);
        u_host.wr(8'h04, 8'h00);
        u_host.wr(8'h05, 8'h3F);
        u_host.wr(ldc_pkg::ADDR_BANK_E, 8'h00);
        u_host.wr(ldc_pkg::ADDR_GROUP, 8'h03);
        u_host.wr(ldc_pkg::ADDR_BANK_A, 8'h3F);
        wait_cyc(300);
        cur_chk(6'h17);
        rd_chk(ldc_pkg::ADDR_STATUS, 8'hFC, "status settled");
        u_host.wr(ldc_pkg::ADDR_GROUP, 8'h3F);
        wait_cyc(10);
        cur_chk(6'h3F);
        u_host.wr(ldc_pkg::ADDR_GROUP, 8'h03);
        wait_cyc(10);
        cur_chk(6'h17);
        $display("test currents and grouping done");
        for (int rc = 0; rc < 4; rc++) begin
            u_host.wr(ldc_pkg::ADDR_GROUP, {2'(rc), 6'h03});
            u_host.wr(ldc_pkg::ADDR_BANK_A, rc[0] ? 8'h3F : 8'h3C);
            rd_chk(ldc_pkg::ADDR_STATUS, rc[0] ? 8'hF2 : 8'hFE, "ramp start");
            wait_cyc(2 * STEP_C[rc] - 5);
            u_host.rd(ldc_pkg::ADDR_STATUS, r);
            chk8(r & 8'h02, 8'h02, "ramp busy");
            wait_cyc(STEP_C[rc] + 8);
            rd_chk(ldc_pkg::ADDR_STATUS, rc[0] ? 8'hFC : 8'hF0, "ramp end");
        end
        $display("test ramp rates done");
        u_host.wr(ldc_pkg::ADDR_GP, 8'hBF);
        u_host.set_pin(1'b0);
        wait_cyc(3);
        chk8({2'b00, led_on}, 8'h00, "pwm low gate");
        chk8({7'h00, chip_en}, 8'h01, "pwm chip on");
        cur_chk(6'h17);
        rd_chk(ldc_pkg::ADDR_GP, 8'hBF, "pwm regs kept");
        u_host.set_pin(1'b1);
        wait_cyc(3);
        chk8({2'b00, led_on}, 8'h3F, "pwm high gate");
        u_host.wr(ldc_pkg::ADDR_GP, 8'h3F);
        u_host.set_pin(1'b0);
        wait_cyc(3);
        chk8({6'h00, chip_en, |led_on}, 8'h00, "enable low");
        rd_chk(ldc_pkg::ADDR_GROUP, 8'h00, "read while disabled");
        u_host.set_pin(1'b1);
        rd_chk(ldc_pkg::ADDR_GP, 8'h00, "gp after low");
        rd_chk(8'h03, 8'h00, "bank after low");
        $display("test pin function done");
        u_host.wr(ldc_pkg::ADDR_GP, 8'h01);
        @(posedge clk_sys_i);
        loss <= 6'h02;
        wait_cyc(4);
        chk8({7'h00, pump}, 8'h00, "loss on dark led");
        loss <= 6'h01;
        wait_cyc(3);
        chk8({7'h00, pump}, 8'h01, "loss on lit led");
        loss <= 6'h00;
        wait_cyc(4);
        chk8({7'h00, pump}, 8'h01, "cathode low");
        cath <= 6'h01;
        wait_cyc(3);
        chk8({7'h00, pump}, 8'h00, "cathode high");
        $display("test pump mode done");
        end_sim();
    end
endmodule
